//--- rtl/codec_pkg.sv
// Constants and types shared by the reader-side proximity frame codec
package codec_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLOCK_HZ = 125_000_000;
	localparam int SUBCARRIER_HZ = 847_500;
	// Subcarrier period in clocks, rounded down
	localparam int SC_CYCLES = CLOCK_HZ / SUBCARRIER_HZ;
	localparam int SC_HALF = SC_CYCLES / 2;
	localparam int MAX_SC_PER_BIT = 8;
	localparam int TMR_W = 12;
	localparam int RUN_W = 8;
	// Half-period runs at least this long mark a phase reversal
	localparam logic [RUN_W-1:0] SC_FLIP = RUN_W'(SC_HALF + SC_HALF / 2);
	// No edge for this long means the subcarrier is off
	localparam logic [RUN_W-1:0] SC_LOST = RUN_W'(3 * SC_HALF);

	// ------------------------------------------------------------------
	// Framing
	// ------------------------------------------------------------------
	localparam int DATA_BITS = 8;
	localparam logic [3:0] CHAR_BITS = 4'h000a;
	localparam logic [3:0] DELIM_BITS = 4'h000a;
	localparam logic [3:0] SOF_STOP_BITS = 4'h0002;
	localparam logic [3:0] LAST_SAMPLE = 4'h0008;
	localparam logic [7:0] MIN_FRAME_BYTES = 8'h0003;
	localparam int FIFO_WIDTH = DATA_BITS + 1;
	localparam int FIFO_DEPTH = 16;

	// ------------------------------------------------------------------
	// Checksum
	// ------------------------------------------------------------------
	localparam logic [15:0] CRC_PRESET = 16'hffff;
	localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
	localparam logic [15:0] CRC_RESIDUE = 16'hf0b8;

	// ------------------------------------------------------------------
	// States
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {TX_IDLE, TX_SOF, TX_SOF_STOP, TX_CHAR, TX_EOF} tx_state_e;
	typedef enum logic [1:0] {SRC_FIFO, SRC_CRC_LO, SRC_CRC_HI, SRC_EOF} tx_src_e;
	typedef enum logic [1:0] {RX_IDLE, RX_SOF, RX_GAP, RX_BITS} rx_state_e;

	function automatic logic [TMR_W-1:0] bit_cycles(input logic [1:0] rate);
		return TMR_W'(SC_CYCLES) << (2'h3 - rate);
	endfunction

endpackage

//--- rtl/crc16_ccitt.sv
// Byte-wide reflected CRC-CCITT register
`timescale 1ns/1ps
`default_nettype none
module crc16_ccitt
	import codec_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic init,
	input wire logic en,
	input wire logic [7:0] data,
	output logic [15:0] crc
);
	typedef struct packed {
		logic [15:0] crc;
	} crc_s;

	crc_s q, d;

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h0000, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY_REFL) : (r >> 1);
		end
		return r;
	endfunction

	assign crc = q.crc;

	always_comb begin
		d = q;
		if (init) begin
			d.crc = CRC_PRESET;
		end else if (en) begin
			d.crc = crc_byte(q.crc, data);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q.crc <= CRC_PRESET;
		end else begin
			q <= d;
		end
	end
endmodule // crc16_ccitt
`default_nettype wire

//--- rtl/reader_codec.sv
// Reader-side frame codec: ASK downlink framer and BPSK uplink deframer
// Contract
// R1 - Reader alone starts exchanges; never transmit and receive at once.
// R2 - Character: START bit, eight data bits, one or more STOP bits.
// R3 - Data bits go least significant first.
// R4 - Frames open with SOF, close with EOF: nine zero data bits each.
// R5 - SOF ends with two STOP bits before the first data character.
// R6 - A frame holds at least three bytes between delimiters.
// R7 - Last two bytes are inverted CRC-CCITT over preceding bytes; sender makes, receiver checks.
// R8 - Checksum low byte goes first, then high byte.
// R9 - Command and parameter bytes sit between SOF and checksum, carried unchanged.
// R10 - Downlink START or zero is modulated carrier; STOP or one is unmodulated.
// R11 - Downlink EOF finishes with unmodulated carrier, not STOP bits.
// R12 - Uplink BPSK bits last eight, four, two or one subcarrier periods.
// R13 - Fob turns subcarrier on just before SOF and off after EOF.
// R14 - Phase before SOF is reference, a one; each bit change flips phase.
// R15 - First uplink reversal is one-to-zero and starts the SOF.
// R16 - Memory access blocks only once the fob is active.
// R17 - Block prologue: PCB, optional CID, optional NAD, at most three bytes.
// R18 - Block epilogue is the checksum, right before EOF.
// R19 - Fob drops I-blocks with chaining or NAD bit set.
// R20 - Fob ignores CID mismatch; replies carry CID when request did.
// R21 - First information byte of an I-block reply is status, 00h success.
// R22 - Fob silently drops frames with bad checksum or too few bytes.
// R23 - CRC polynomial x16+x12+x5+1, preset all ones, LSB first, then inverted.
`timescale 1ns/1ps
`default_nettype none
module reader_codec
	import codec_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic [1:0] rate_sel,
	input wire logic block_mode,
	input wire logic fob_active,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic tx_busy,
	output logic mod_out,
	input wire logic sc_in,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic rx_done,
	output logic rx_ok,
	output logic [7:0] rx_pcb
);
	// ------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------
	logic [1:0] rst_sync_q;
	logic rst_n;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rst_sync_q <= 2'h0000;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ------------------------------------------------------------------
	// Buffer and checksum units
	// ------------------------------------------------------------------
	stream_if #(.WIDTH(FIFO_WIDTH)) in_if ();
	stream_if #(.WIDTH(FIFO_WIDTH)) out_if ();

	assign in_if.data = {tx_last, tx_data};
	assign in_if.valid = tx_valid;
	assign tx_ready = in_if.ready;

	word_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.in_port(in_if),
		.out_port(out_if)
	);

	typedef struct packed {
		tx_state_e tx_st;
		tx_src_e tx_src;
		logic [9:0] tx_sh;
		logic [3:0] tx_bits;
		logic [TMR_W-1:0] tx_tmr;
		logic mod;
		rx_state_e rx_st;
		logic sc_prev;
		logic sc_on;
		logic rx_inv;
		logic [RUN_W-1:0] run;
		logic [TMR_W-1:0] rx_tmr;
		logic [3:0] rx_bits;
		logic [8:0] rx_sh;
		logic [7:0] rx_len;
		logic [7:0] rx_data;
		logic rx_valid;
		logic rx_done;
		logic rx_ok;
		logic [7:0] rx_pcb;
	} codec_s;

	codec_s q, d;
	logic [15:0] tx_crc;
	logic [15:0] rx_crc;
	logic tx_start;
	logic pop;
	logic tick;
	logic rx_init;
	logic rx_byte;
	logic edge_seen;
	logic flip;
	logic lost;
	logic [8:0] samp;
	logic [TMR_W-1:0] bc;

	crc16_ccitt u_tx_crc (
		.clock(clock),
		.rst_n(rst_n),
		.init(tx_start),
		.en(pop),
		.data(out_if.data[7:0]),
		.crc(tx_crc)
	);

	crc16_ccitt u_rx_crc (
		.clock(clock),
		.rst_n(rst_n),
		.init(rx_init),
		.en(rx_byte),
		.data(samp[7:0]),
		.crc(rx_crc)
	);

	assign out_if.ready = pop;
	assign tx_busy = (q.tx_st != TX_IDLE);
	assign mod_out = q.mod;
	assign rx_data = q.rx_data;
	assign rx_valid = q.rx_valid;
	assign rx_done = q.rx_done;
	assign rx_ok = q.rx_ok;
	assign rx_pcb = q.rx_pcb;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		d = q;
		bc = bit_cycles(rate_sel); // R12
		tick = (q.tx_st != TX_IDLE) && (q.tx_tmr == '0);
		pop = 1'b0;
		tx_start = 1'b0;
		rx_init = 1'b0;
		rx_byte = 1'b0;
		d.rx_valid = 1'b0;
		d.rx_done = 1'b0;

		// Downlink framer
		if (q.tx_st == TX_IDLE) begin
			// Hold off while the fob's subcarrier is up, even before its SOF
			if (out_if.valid && q.rx_st == RX_IDLE && !q.sc_on && !(block_mode && !fob_active)) begin // R1 R16
				tx_start = 1'b1;
				d.tx_st = TX_SOF;
				d.tx_src = SRC_FIFO;
				d.tx_sh = '0; // R4
				d.tx_bits = DELIM_BITS;
				d.tx_tmr = TMR_W'(bc - 1'b1);
			end
		end else if (!tick) begin
			d.tx_tmr = TMR_W'(q.tx_tmr - 1'b1);
		end else if (q.tx_bits > 4'h0001) begin
			d.tx_sh = {1'b1, q.tx_sh[9:1]}; // R3
			d.tx_bits = 4'(q.tx_bits - 1'b1);
			d.tx_tmr = TMR_W'(bc - 1'b1);
		end else begin
			d.tx_tmr = TMR_W'(bc - 1'b1);
			case (q.tx_st)
				TX_SOF: begin
					d.tx_st = TX_SOF_STOP;
					d.tx_sh = '1;
					d.tx_bits = SOF_STOP_BITS; // R5
				end
				TX_SOF_STOP, TX_CHAR: begin
					d.tx_st = TX_CHAR;
					d.tx_bits = CHAR_BITS;
					case (q.tx_src)
						SRC_FIFO: begin
							if (out_if.valid) begin
								pop = 1'b1;
								d.tx_sh = {1'b1, out_if.data[7:0], 1'b0}; // R2 R9
								if (out_if.data[DATA_BITS]) begin
									d.tx_src = SRC_CRC_LO;
								end
							end else begin
								// Extra STOP bit while the buffer catches up
								d.tx_sh = '1; // R2
								d.tx_bits = 4'h0001;
							end
						end
						SRC_CRC_LO: begin
							d.tx_sh = {1'b1, ~tx_crc[7:0], 1'b0}; // R7 R8 R23
							d.tx_src = SRC_CRC_HI;
						end
						SRC_CRC_HI: begin
							d.tx_sh = {1'b1, ~tx_crc[15:8], 1'b0}; // R8 R18
							d.tx_src = SRC_EOF;
						end
						default: begin
							d.tx_st = TX_EOF;
							d.tx_sh = '0; // R4
							d.tx_bits = DELIM_BITS;
						end
					endcase
				end
				default: begin
					d.tx_st = TX_IDLE; // R11
					d.tx_sh = '0;
				end
			endcase
		end
		d.mod = (d.tx_st != TX_IDLE) && !d.tx_sh[0]; // R10 R11

		// Uplink subcarrier tracking
		edge_seen = (sc_in != q.sc_prev);
		d.sc_prev = sc_in;
		lost = (q.run == SC_LOST);
		flip = edge_seen && q.sc_on && (q.run >= SC_FLIP);
		if (edge_seen) begin
			d.run = '0;
		end else if (!lost) begin
			d.run = RUN_W'(q.run + 1'b1);
		end
		if (tx_busy || (lost && !edge_seen)) begin
			d.sc_on = 1'b0; // R1 R13
			d.rx_inv = 1'b0;
		end else if (edge_seen && !q.sc_on) begin
			d.sc_on = 1'b1; // R13
			d.rx_inv = 1'b0; // R14
		end else if (flip) begin
			d.rx_inv = !q.rx_inv; // R14
		end

		// Uplink deframer
		samp = {!q.rx_inv, q.rx_sh[8:1]};
		case (q.rx_st)
			RX_IDLE: begin
				if (flip && !q.rx_inv && !tx_busy) begin
					rx_init = 1'b1; // R15
					d.rx_st = RX_SOF;
					d.rx_len = '0;
				end
			end
			RX_SOF: begin
				if (flip) begin
					d.rx_st = RX_GAP;
				end
			end
			RX_GAP: begin
				if (flip && !q.rx_inv) begin
					d.rx_st = RX_BITS;
					d.rx_bits = '0;
					d.rx_tmr = TMR_W'(bc + (bc >> 1) - 1'b1); // R12
				end
			end
			RX_BITS: begin
				if (q.rx_tmr != '0) begin
					d.rx_tmr = TMR_W'(q.rx_tmr - 1'b1);
				end else begin
					d.rx_sh = samp; // R3
					d.rx_bits = 4'(q.rx_bits + 1'b1);
					d.rx_tmr = TMR_W'(bc - 1'b1);
					if (q.rx_bits == LAST_SAMPLE) begin
						if (samp[8]) begin
							rx_byte = 1'b1; // R2
							d.rx_data = samp[7:0];
							d.rx_valid = 1'b1;
							if (q.rx_len == '0) begin
								d.rx_pcb = samp[7:0]; // R17
							end
							if (q.rx_len != '1) begin
								d.rx_len = 8'(q.rx_len + 1'b1);
							end
							d.rx_st = RX_GAP;
						end else begin
							// EOF when all nine data bits are zero, framing error otherwise
							d.rx_done = 1'b1; // R4
							d.rx_ok = (samp == '0) && (rx_crc == CRC_RESIDUE)
								&& (q.rx_len >= MIN_FRAME_BYTES); // R6 R7 R23
							d.rx_st = RX_IDLE;
						end
					end
				end
			end
			default: begin
				d.rx_st = RX_IDLE;
			end
		endcase
		if (q.rx_st != RX_IDLE && !q.sc_on) begin
			d.rx_done = 1'b1; // R13
			d.rx_ok = 1'b0;
			d.rx_st = RX_IDLE;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_half_duplex: assert property (tx_busy |-> q.rx_st == RX_IDLE) // R1
		else $error("receiver active during transmit");
	a_char_frame: assert property ((q.tx_st == TX_CHAR && q.tx_bits == CHAR_BITS) |-> (!q.tx_sh[0] && q.tx_sh[9])) // R2
		else $error("character without start or stop bit");
	a_lsb_first: assert property ((tick && q.tx_st == TX_CHAR && q.tx_bits > 4'h0001) |=> q.tx_sh[7:0] == $past(q.tx_sh[8:1])) // R3
		else $error("data bits not shifted lsb first");
	a_sof_stops: assert property ((q.tx_st == TX_SOF ##1 q.tx_st == TX_SOF_STOP) |-> q.tx_bits == SOF_STOP_BITS && !q.mod) // R5
		else $error("sof not followed by two stop bits");
	a_sof_zeros: assert property ((q.tx_st == TX_IDLE ##1 q.tx_st == TX_SOF) |-> q.mod [*8]) // R4
		else $error("sof not modulated");
	a_mod_level: assert property ((q.tx_st != TX_IDLE) |-> q.mod == !q.tx_sh[0]) // R10
		else $error("modulation does not follow bit");
	a_eof_release: assert property ((tick && q.tx_st == TX_EOF && q.tx_bits == 4'h0001) |=> (!q.mod && q.tx_st == TX_IDLE)) // R11
		else $error("eof not ended by unmodulated carrier");
	a_crc_low_first: assert property ((tick && q.tx_st == TX_CHAR && q.tx_bits == 4'h0001 // R8
		&& q.tx_src == SRC_CRC_LO) |=> (q.tx_sh[8:1] == ~tx_crc[7:0] && q.tx_src == SRC_CRC_HI))
		else $error("checksum low byte not first");
	a_rx_good: assert property ((q.rx_done && q.rx_ok) |-> (rx_crc == CRC_RESIDUE && q.rx_len >= MIN_FRAME_BYTES)) // R7
		else $error("frame accepted with bad checksum or length");
	a_phase_ref: assert property (!q.sc_on |-> !q.rx_inv) // R14
		else $error("phase reference not restored");
	a_first_flip: assert property ((q.rx_st == RX_IDLE ##1 q.rx_st == RX_SOF) |-> q.rx_inv) // R15
		else $error("frame start not on one-to-zero reversal");

	c_tx_frame: cover property (q.tx_st == TX_EOF ##1 q.tx_st == TX_IDLE);
	c_rx_good: cover property (q.rx_done && q.rx_ok);
	c_rx_bad: cover property (q.rx_done && !q.rx_ok);
	c_fifo_full: cover property (tx_valid && !tx_ready);
endmodule // reader_codec
`default_nettype wire

//--- rtl/stream_if.sv
// Valid/ready word stream between the codec's own modules
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int WIDTH = 9);
	logic [WIDTH-1:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

//--- rtl/word_fifo.sv
// Word FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none
module word_fifo
	import codec_pkg::*;
#(
	parameter int WIDTH = FIFO_WIDTH,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic rst_n,
	stream_if.snk in_port,
	stream_if.src out_port
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
		logic ov;
		logic [WIDTH-1:0] od;
	} fifo_s;

	fifo_s q, d;
	logic wr_en;
	logic rd_en;

	assign in_port.ready = (q.cnt != (AW+1)'(DEPTH));
	assign out_port.valid = q.ov;
	assign out_port.data = q.od;

	always_comb begin
		d = q;
		wr_en = in_port.valid && in_port.ready;
		rd_en = (q.cnt != '0) && (!q.ov || out_port.ready);
		if (wr_en) begin
			d.mem[q.wr] = in_port.data;
			d.wr = AW'(q.wr + 1'b1);
		end
		if (rd_en) begin
			d.od = q.mem[q.rd];
			d.ov = 1'b1;
			d.rd = AW'(q.rd + 1'b1);
		end else if (out_port.ready) begin
			d.ov = 1'b0;
		end
		d.cnt = (AW+1)'(q.cnt + (AW+1)'(wr_en) - (AW+1)'(rd_en));
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule // word_fifo
`default_nettype wire

//--- test/fob_model.sv
// Behavioural fob: BPSK uplink frame generator
`timescale 1ns/1ps
`default_nettype none
module fob_model
	import codec_pkg::*;
(
	input wire logic clock,
	input wire logic [1:0] rate_sel,
	input wire logic go,
	input wire logic [31:0] payload,
	input wire logic [2:0] n,
	input wire logic bad,
	output logic sc_in
);
	logic q[$];
	logic [7:0] b[$];
	logic [15:0] c;
	int t;

	function automatic logic [15:0] crc16(input logic [7:0] d[$]);
		logic [15:0] r;
		r = 16'hffff;
		foreach (d[j])
			for (int i = 0; i < 8; i++)
				r = (r[0] ^ d[j][i]) ? ((r >> 1) ^ 16'h8408) : (r >> 1);
		return ~r;
	endfunction

	task automatic add(input logic v, input int k);
		repeat (k) q.push_back(v);
	endtask

	// ------------------------------------------------------------------
	// Response frame, sent only when asked
	// ------------------------------------------------------------------
	initial sc_in = 1'b0;
	always @(posedge go) begin
		b = {};
		for (int i = 0; i < n; i++)
			b.push_back(payload[8*i +: 8]);
		// Flipped checksum bit when a bad frame is wanted
		c = crc16(b) ^ {15'h0000, bad};
		b.push_back(c[7:0]);
		b.push_back(c[15:8]);
		q = {};
		add(1'b1, 2);
		add(1'b0, 10);
		add(1'b1, 2);
		foreach (b[j]) begin
			add(1'b0, 1);
			for (int i = 0; i < 8; i++)
				add(b[j][i], 1);
			add(1'b1, 1);
		end
		add(1'b0, 10);
		t = SC_CYCLES << (3 - rate_sel);
		foreach (q[j])
			for (int k = 0; k < t; k++) begin
				@(negedge clock);
				sc_in = ((k % SC_CYCLES) < SC_HALF) == q[j];
			end
		@(negedge clock);
		sc_in = 1'b0;
	end
endmodule // fob_model
`default_nettype wire

//--- test/reader_codec_tb.sv
// Self-checking bench for the reader-side frame codec
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		num_errors++; \
		$display("[FAIL] %s exp %h got %h", nm, e, g); \
	end \
end
module reader_codec_tb
	import codec_pkg::*;
;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic block_mode = 1'b0;
	logic fob_active = 1'b0;
	logic tx_last = 1'b0;
	logic tx_valid = 1'b0;
	logic go = 1'b0;
	logic bad = 1'b0;
	logic [1:0] rate_sel = 2'h3;
	logic [7:0] tx_data = 8'h00;
	logic [31:0] payload = 32'h0000_0000;
	logic [2:0] n = 3'h0;
	logic tx_ready, tx_busy, mod_out, sc_in, rx_valid, rx_done, rx_ok;
	logic [7:0] rx_data, rx_pcb;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;

	reader_codec i_reader_codec (.clock(clock), .nrst(nrst), .rate_sel(rate_sel), .block_mode(block_mode),
		.fob_active(fob_active), .tx_data(tx_data), .tx_last(tx_last), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_busy(tx_busy), .mod_out(mod_out), .sc_in(sc_in), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_done(rx_done), .rx_ok(rx_ok), .rx_pcb(rx_pcb));
	fob_model i_fob_model (.clock(clock), .rate_sel(rate_sel), .go(go), .payload(payload), .n(n),
		.bad(bad), .sc_in(sc_in));

	always #4 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 99000) begin
			num_errors++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic wait_busy(input logic v, input int lim);
		int k;
		k = 0;
		while (tx_busy !== v && k < lim) begin
			@(negedge clock);
			k++;
		end
		if (k == lim) begin
			num_errors++;
			$display("[FAIL] tx_busy exp %h got %h", v, tx_busy);
		end
	endtask

	// Leaves tx_valid high so back-to-back pushes never retoggle it
	task automatic push(input logic [7:0] b, input logic l);
		tx_data = b;
		tx_last = l;
		tx_valid = 1'b1;
		while (tx_ready !== 1'b1)
			@(negedge clock);
		@(negedge clock);
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		repeat (4) @(negedge clock);
		`CHK("tx_ready", 1'b1, tx_ready)
		`CHK("mod_out", 1'b0, mod_out)
	endtask

	task automatic t_down(input logic [1:0] r);
		logic [7:0] q[$];
		logic e[$];
		logic [15:0] c;
		int t;
		rate_sel = r;
		q = {8'ha5, 8'h3c};
		push(q[0], 1'b0);
		push(q[1], 1'b1);
		tx_valid = 1'b0;
		c = i_fob_model.crc16(q);
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		repeat (10) e.push_back(1'b1);
		repeat (2) e.push_back(1'b0);
		foreach (q[j]) begin
			e.push_back(1'b1);
			for (int i = 0; i < 8; i++)
				e.push_back(~q[j][i]);
			e.push_back(1'b0);
		end
		repeat (10) e.push_back(1'b1);
		t = SC_CYCLES << (3 - r);
		wait_busy(1'b1, 20);
		repeat (t / 2 + 1) @(negedge clock);
		foreach (e[i]) begin
			`CHK("mod_out", e[i], mod_out)
			repeat (t) @(negedge clock);
		end
		`CHK("mod_out", 1'b0, mod_out)
		`CHK("tx_busy", 1'b0, tx_busy)
	endtask

	task automatic t_up(input logic [31:0] pl, input logic [2:0] cnt, input logic bd, input logic ok,
		input logic dur);
		logic [7:0] q[$];
		logic [7:0] got[$];
		logic [15:0] c;
		logic bz;
		int k;
		rate_sel = 2'h3;
		payload = pl;
		n = cnt;
		bad = bd;
		for (int i = 0; i < cnt; i++)
			q.push_back(pl[8*i +: 8]);
		c = i_fob_model.crc16(q) ^ {15'h0000, bd};
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		go = 1'b1;
		@(negedge clock);
		go = 1'b0;
		repeat (3) @(negedge clock);
		if (dur) begin
			push(8'h77, 1'b1);
			tx_valid = 1'b0;
		end
		bz = 1'b0;
		k = 0;
		while (rx_done !== 1'b1 && k < 20000) begin
			if (rx_valid === 1'b1)
				got.push_back(rx_data);
			if (tx_busy !== 1'b0)
				bz = 1'b1;
			@(negedge clock);
			k++;
		end
		`CHK("rx_done", 1'b1, rx_done)
		`CHK("rx_ok", ok, rx_ok)
		`CHK("count", q.size(), got.size())
		foreach (q[i])
			`CHK("rx_data", q[i], got[i])
		`CHK("rx_pcb", q[0], rx_pcb)
		if (dur) begin
			`CHK("held", 1'b0, bz)
			// Transmit waits for the subcarrier to drop after EOF
			wait_busy(1'b1, 400);
			wait_busy(1'b0, 12000);
		end
		repeat (2000) @(negedge clock);
	endtask

	task automatic t_fill();
		int cnt;
		block_mode = 1'b1;
		fob_active = 1'b0;
		rate_sel = 2'h3;
		cnt = 0;
		tx_valid = 1'b1;
		for (int i = 0; i < 20; i++) begin
			tx_data = 8'(i);
			tx_last = (i == FIFO_DEPTH);
			if (tx_ready === 1'b1)
				cnt++;
			@(negedge clock);
		end
		tx_valid = 1'b0;
		`CHK("accepted", FIFO_DEPTH + 1, cnt)
		`CHK("tx_busy", 1'b0, tx_busy)
		fob_active = 1'b1;
		wait_busy(1'b1, 20);
		wait_busy(1'b0, 33000);
		`CHK("tx_ready", 1'b1, tx_ready)
		block_mode = 1'b0;
	endtask

	initial begin
		repeat (5) @(negedge clock);
		nrst = 1'b1;
		t_reset();
		t_down(2'h2);
		// Success reply: PCB with CID flag, CID 0, status 00h
		t_up(32'h0000_000a, 3'h3, 1'b0, 1'b1, 1'b0);
		t_up(32'h0000_0033, 3'h1, 1'b1, 1'b0, 1'b1);
		t_up(32'h0000_0000, 3'h0, 1'b0, 1'b0, 1'b0);
		t_fill();
		final_report();
	end
endmodule // reader_codec_tb
`default_nettype wire
